// *** hdl/lpf_pkg.sv ***
// constants and types shared by the lighting register bank
package lpf_pkg;
  // register offsets on the serial bus
  localparam logic [7:0] ADDR_BOOST   = 8'h0D;
  localparam logic [7:0] ADDR_FREQ    = 8'h0E;
  localparam logic [7:0] ADDR_FLASH   = 8'h10;
  localparam logic [7:0] ADDR_PATTERN = 8'h11;
  localparam logic [7:0] ADDR_CEIL1   = 8'h12;
  localparam logic [7:0] ADDR_CEIL2   = 8'h13;

  // reset values
  localparam logic [7:0] RST_BOOST   = 8'h3F;
  localparam logic [7:0] RST_FREQ    = 8'h07;
  localparam logic [7:0] RST_FLASH   = 8'h00;
  localparam logic [7:0] RST_PATTERN = 8'h00;
  localparam logic [7:0] RST_CEIL    = 8'h00;

  // writable bits of each register
  localparam logic [7:0] MASK_BOOST   = 8'hFF;
  localparam logic [7:0] MASK_FREQ    = 8'h07;
  localparam logic [7:0] MASK_FLASH   = 8'h7F;
  localparam logic [7:0] MASK_PATTERN = 8'h0F;
  localparam logic [7:0] MASK_CEIL    = 8'h3F;

  // field positions
  localparam int FREQ_TOP_BIT   = 2;
  localparam int FREQ_MID_BIT   = 1;
  localparam int FL_EN_BIT      = 0;
  localparam int FL_CUR_LSB     = 1;
  localparam int FL_DUR_LSB     = 3;
  localparam int FL_DIM_BIT     = 5;
  localparam int FL_SAFE_BIT    = 6;
  localparam int PG_MODE_BIT    = 0;
  localparam int PG_LOOP_BIT    = 1;
  localparam int PG_START_BIT   = 2;
  localparam int PG_BLINK_BIT   = 3;
  localparam int CEIL_BLUE_LSB  = 0;
  localparam int CEIL_GREEN_LSB = 2;
  localparam int CEIL_RED_LSB   = 4;

  // frequency select codes
  localparam logic [1:0] FREQ_1M00 = 2'h0;
  localparam logic [1:0] FREQ_1M67 = 2'h1;
  localparam logic [1:0] FREQ_2M00 = 2'h2;

  // flash duration code held by the trigger pin
  localparam logic [1:0] DUR_PIN = 2'h3;

  // timing
  localparam int unsigned CLK_KHZ    = 200000;
  localparam int unsigned DUR0_MS    = 200;
  localparam int unsigned DUR1_MS    = 400;
  localparam int unsigned DUR2_MS    = 600;
  localparam int          TMR_W      = 27;

  // serial slave states, one-hot
  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_ADDR  = 9'h002,
    ST_AACK  = 9'h004,
    ST_PTR   = 9'h008,
    ST_PACK  = 9'h010,
    ST_WDATA = 9'h020,
    ST_WACK  = 9'h040,
    ST_RDATA = 9'h080,
    ST_RACK  = 9'h100
  } lpf_i2c_state_t;
endpackage : lpf_pkg

// *** hdl/lpf_flash_if.sv ***
// control and drive signals between register bank and flash timer
`timescale 1ns/1ps
interface lpf_flash_if;
  logic       drv_en;
  logic       safe_en;
  logic       dim_en;
  logic [1:0] dur;
  logic       trig;
  logic       dim;
  logic       drive;

  modport ctrl  (output drv_en, safe_en, dim_en, dur, trig, dim, input drive);
  modport timer (input drv_en, safe_en, dim_en, dur, trig, dim, output drive);
endinterface : lpf_flash_if

// *** hdl/lpf_pin_sync.sv ***
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module lpf_pin_sync #(
  parameter logic RST_LVL = 1'b0
) (
  // clock and reset
  input  wire logic mclk_in,
  input  wire logic resetn_in,
  // pin and filtered level
  input  wire logic pin_in,
  output logic      level_out
);
  logic s1_q, s2_q, s3_q, lvl_q, lvl_d;

  // level moves only when stages two and three agree
  always_comb begin
    lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
  end

  // first stage is read by the second alone
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      s1_q  <= RST_LVL;
      s2_q  <= RST_LVL;
      s3_q  <= RST_LVL;
      lvl_q <= RST_LVL;
    end else begin
      s1_q  <= pin_in;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign level_out = lvl_q;
endmodule : lpf_pin_sync

// *** hdl/lpf_flash_timer.sv ***
// flash driver on-time control with duration timer and dimming gate
`timescale 1ns/1ps
module lpf_flash_timer #(
  parameter int unsigned DUR0_CYC = 40000000,
  parameter int unsigned DUR1_CYC = 80000000,
  parameter int unsigned DUR2_CYC = 120000000
) (
  // clock and reset
  input  wire logic mclk_in,
  input  wire logic resetn_in,
  // control from the register bank
  lpf_flash_if.timer fl
);
  logic                     act_q, act_d;
  logic                     trig_q, trig_d;
  logic                     drv_q, drv_d;
  logic [lpf_pkg::TMR_W-1:0] cnt_q, cnt_d;
  logic [lpf_pkg::TMR_W-1:0] lim;

  // next flash state; pin-held mode is capped at the longest time when guarded
  always_comb begin
    case (fl.dur)
      2'h0:    lim = lpf_pkg::TMR_W'(DUR0_CYC);
      2'h1:    lim = lpf_pkg::TMR_W'(DUR1_CYC);
      default: lim = lpf_pkg::TMR_W'(DUR2_CYC);
    endcase
    act_d  = act_q;
    cnt_d  = cnt_q;
    trig_d = fl.trig;
    if (!fl.drv_en) begin
      act_d = 1'b0;
    end else if (fl.trig && !trig_q) begin
      act_d = 1'b1;
      cnt_d = '0;
    end else if (act_q) begin
      if (fl.dur == lpf_pkg::DUR_PIN && !fl.trig) begin
        act_d = 1'b0;
      end else if ((fl.dur != lpf_pkg::DUR_PIN || fl.safe_en) && cnt_q >= lim - 1'b1) begin
        act_d = 1'b0;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
    drv_d = act_d && (!fl.dim_en || fl.dim);
  end

  // flash state registers
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      act_q  <= 1'b0;
      trig_q <= 1'b0;
      drv_q  <= 1'b0;
      cnt_q  <= '0;
    end else begin
      act_q  <= act_d;
      trig_q <= trig_d;
      drv_q  <= drv_d;
      cnt_q  <= cnt_d;
    end
  end

  assign fl.drive = drv_q;
endmodule : lpf_flash_timer

// *** hdl/lpf_regs.sv ***
// lighting power, flash and pattern register bank behind a serial slave
`timescale 1ns/1ps
module lpf_regs #(
  parameter logic [6:0]  DEV_ADDR = 7'h2A, // bus address, arbitrary
  parameter int unsigned DUR0_CYC = lpf_pkg::DUR0_MS * lpf_pkg::CLK_KHZ,
  parameter int unsigned DUR1_CYC = lpf_pkg::DUR1_MS * lpf_pkg::CLK_KHZ,
  parameter int unsigned DUR2_CYC = lpf_pkg::DUR2_MS * lpf_pkg::CLK_KHZ
) (
  // clock and reset
  input  wire logic       mclk_in,
  input  wire logic       resetn_in,
  // serial bus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n_out,
  // flash pins
  input  wire logic       flash_trigger_in,
  input  wire logic       flash_dim_in,
  output logic            flash_drive_out,
  output logic [1:0]      flash_current_select_out,
  // converter settings
  output logic [3:0]      boost_step_out,
  output logic [1:0]      freq_mode_out,
  // pattern generator controls
  output logic            blink_enable_out,
  output logic            pattern_run_out,
  output logic            pattern_restart_out,
  output logic            pattern_loop_out,
  output logic            intensity_mode_out,
  // colour ceilings
  output logic [1:0]      group1_red_ceiling_out,
  output logic [1:0]      group1_green_ceiling_out,
  output logic [1:0]      group1_blue_ceiling_out,
  output logic [1:0]      group2_red_ceiling_out,
  output logic [1:0]      group2_green_ceiling_out,
  output logic [1:0]      group2_blue_ceiling_out
);
  // filtered pin levels; bus pins idle high, flash pins idle low
  logic scl_lvl, sda_lvl, trig_lvl, dim_lvl;
  lpf_pin_sync #(.RST_LVL(1'b1)) u_scl (.mclk_in(mclk_in), .resetn_in(resetn_in),
    .pin_in(scl_in), .level_out(scl_lvl));
  lpf_pin_sync #(.RST_LVL(1'b1)) u_sda (.mclk_in(mclk_in), .resetn_in(resetn_in),
    .pin_in(sda_in), .level_out(sda_lvl));
  lpf_pin_sync #(.RST_LVL(1'b0)) u_trig (.mclk_in(mclk_in), .resetn_in(resetn_in),
    .pin_in(flash_trigger_in), .level_out(trig_lvl));
  lpf_pin_sync #(.RST_LVL(1'b0)) u_dim (.mclk_in(mclk_in), .resetn_in(resetn_in),
    .pin_in(flash_dim_in), .level_out(dim_lvl));

  // bus slave state
  lpf_pkg::lpf_i2c_state_t st_q, st_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [7:0]  sh_q, sh_d;
  logic [7:0]  ptr_q, ptr_d;
  logic        rw_q, rw_d;
  logic        nack_q, nack_d;
  logic        oe_n_q, oe_n_d;
  logic        scl_prev_q, sda_prev_q;
  logic        sda_q, sda_d;
  logic        wr_en;
  logic [7:0]  rd_byte;
  // register state
  logic [7:0]  boost_q, boost_d;
  logic [7:0]  freq_q, freq_d;
  logic [7:0]  flash_q, flash_d;
  logic [7:0]  pat_q, pat_d;
  logic [7:0]  ceil1_q, ceil1_d;
  logic [7:0]  ceil2_q, ceil2_d;
  logic        restart_q, restart_d;
  logic [3:0]  step_q, step_d;
  logic [1:0]  fmode_q, fmode_d;
  // bus events, judged on filtered levels only
  wire scl_rise = scl_lvl && !scl_prev_q;
  wire scl_fall = !scl_lvl && scl_prev_q;
  wire start_ev = scl_lvl && scl_prev_q && sda_prev_q && !sda_lvl;
  wire stop_ev  = scl_lvl && scl_prev_q && !sda_prev_q && sda_lvl;
  // read mux; unmapped offsets and reserved bits read zero
  always_comb begin
    case (ptr_q)
      lpf_pkg::ADDR_BOOST:   rd_byte = boost_q;
      lpf_pkg::ADDR_FREQ:    rd_byte = freq_q & lpf_pkg::MASK_FREQ;
      lpf_pkg::ADDR_FLASH:   rd_byte = flash_q & lpf_pkg::MASK_FLASH;
      lpf_pkg::ADDR_PATTERN: rd_byte = pat_q & lpf_pkg::MASK_PATTERN;
      lpf_pkg::ADDR_CEIL1:   rd_byte = ceil1_q & lpf_pkg::MASK_CEIL;
      lpf_pkg::ADDR_CEIL2:   rd_byte = ceil2_q & lpf_pkg::MASK_CEIL;
      default:               rd_byte = 8'h00;
    endcase
  end

  // serial slave: pointer byte then data, pointer advances per byte
  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    sh_d   = sh_q;
    ptr_d  = ptr_q;
    rw_d   = rw_q;
    nack_d = nack_q;
    oe_n_d = oe_n_q;
    sda_d  = 1'b0;
    wr_en  = 1'b0;
    if (start_ev) begin
      st_d   = lpf_pkg::ST_ADDR;
      cnt_d  = 4'h0;
      oe_n_d = 1'b1;
    end else if (stop_ev) begin
      st_d   = lpf_pkg::ST_IDLE;
      oe_n_d = 1'b1;
    end else if (scl_rise) begin
      case (st_q)
        lpf_pkg::ST_ADDR, lpf_pkg::ST_PTR, lpf_pkg::ST_WDATA: begin
          sh_d  = {sh_q[6:0], sda_lvl};
          cnt_d = cnt_q + 4'h1;
        end
        lpf_pkg::ST_RACK: nack_d = sda_lvl;
        default: ;
      endcase
    end else if (scl_fall) begin
      case (st_q)
        lpf_pkg::ST_ADDR: begin
          if (cnt_q == 4'h8) begin
            if (sh_q[7:1] == DEV_ADDR) begin
              st_d   = lpf_pkg::ST_AACK;
              rw_d   = sh_q[0];
              oe_n_d = 1'b0;
            end else begin
              st_d = lpf_pkg::ST_IDLE;
            end
          end
        end
        lpf_pkg::ST_AACK: begin
          cnt_d = 4'h0;
          if (rw_q) begin
            st_d   = lpf_pkg::ST_RDATA;
            sh_d   = rd_byte;
            oe_n_d = rd_byte[7];
          end else begin
            st_d   = lpf_pkg::ST_PTR;
            oe_n_d = 1'b1;
          end
        end
        lpf_pkg::ST_PTR: begin
          if (cnt_q == 4'h8) begin
            ptr_d  = sh_q;
            st_d   = lpf_pkg::ST_PACK;
            oe_n_d = 1'b0;
          end
        end
        lpf_pkg::ST_WDATA: begin
          if (cnt_q == 4'h8) begin
            wr_en  = 1'b1;
            st_d   = lpf_pkg::ST_WACK;
            oe_n_d = 1'b0;
          end
        end
        lpf_pkg::ST_PACK, lpf_pkg::ST_WACK: begin
          if (st_q == lpf_pkg::ST_WACK) begin
            ptr_d = ptr_q + 8'h01;
          end
          st_d   = lpf_pkg::ST_WDATA;
          cnt_d  = 4'h0;
          oe_n_d = 1'b1;
        end
        lpf_pkg::ST_RDATA: begin
          if (cnt_q == 4'h7) begin
            st_d   = lpf_pkg::ST_RACK;
            ptr_d  = ptr_q + 8'h01;
            oe_n_d = 1'b1;
          end else begin
            cnt_d  = cnt_q + 4'h1;
            sh_d   = {sh_q[6:0], 1'b0};
            oe_n_d = sh_q[6];
          end
        end
        lpf_pkg::ST_RACK: begin
          if (nack_q) begin
            st_d = lpf_pkg::ST_IDLE;
          end else begin
            st_d   = lpf_pkg::ST_RDATA;
            cnt_d  = 4'h0;
            sh_d   = rd_byte;
            oe_n_d = rd_byte[7];
          end
        end
        default: st_d = lpf_pkg::ST_IDLE;
      endcase
    end
  end

  // bus slave registers
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      st_q       <= lpf_pkg::ST_IDLE;
      cnt_q      <= 4'h0;
      sh_q       <= 8'h00;
      ptr_q      <= 8'h00;
      rw_q       <= 1'b0;
      nack_q     <= 1'b0;
      oe_n_q     <= 1'b1;
      sda_q      <= 1'b0;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      st_q       <= st_d;
      cnt_q      <= cnt_d;
      sh_q       <= sh_d;
      ptr_q      <= ptr_d;
      rw_q       <= rw_d;
      nack_q     <= nack_d;
      oe_n_q     <= oe_n_d;
      sda_q      <= sda_d;
      scl_prev_q <= scl_lvl;
      sda_prev_q <= sda_lvl;
    end
  end
  // register writes; masks keep reserved bits at zero
  always_comb begin
    boost_d   = boost_q;
    freq_d    = freq_q;
    flash_d   = flash_q;
    pat_d     = pat_q;
    ceil1_d   = ceil1_q;
    ceil2_d   = ceil2_q;
    restart_d = 1'b0;
    if (wr_en) begin
      case (ptr_q)
        lpf_pkg::ADDR_BOOST:   boost_d = sh_q & lpf_pkg::MASK_BOOST;
        lpf_pkg::ADDR_FREQ:    freq_d  = sh_q & lpf_pkg::MASK_FREQ;
        lpf_pkg::ADDR_FLASH:   flash_d = sh_q & lpf_pkg::MASK_FLASH;
        lpf_pkg::ADDR_PATTERN: begin
          pat_d     = sh_q & lpf_pkg::MASK_PATTERN;
          // a fresh set restarts from the first slot
          restart_d = sh_q[lpf_pkg::PG_START_BIT] && !pat_q[lpf_pkg::PG_START_BIT];
        end
        lpf_pkg::ADDR_CEIL1:   ceil1_d = sh_q & lpf_pkg::MASK_CEIL;
        lpf_pkg::ADDR_CEIL2:   ceil2_d = sh_q & lpf_pkg::MASK_CEIL;
        default: ;
      endcase
    end
  end
  // register storage
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      boost_q   <= lpf_pkg::RST_BOOST;
      freq_q    <= lpf_pkg::RST_FREQ;
      flash_q   <= lpf_pkg::RST_FLASH;
      pat_q     <= lpf_pkg::RST_PATTERN;
      ceil1_q   <= lpf_pkg::RST_CEIL;
      ceil2_q   <= lpf_pkg::RST_CEIL;
      restart_q <= 1'b0;
    end else begin
      boost_q   <= boost_d;
      freq_q    <= freq_d;
      flash_q   <= flash_d;
      pat_q     <= pat_d;
      ceil1_q   <= ceil1_d;
      ceil2_q   <= ceil2_d;
      restart_q <= restart_d;
    end
  end

  // setting decodes; a broken thermometer counts only the unbroken low run
  always_comb begin
    logic run;
    run    = 1'b1;
    step_d = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (run && boost_q[i]) begin
        step_d = step_d + 4'h1;
      end else begin
        run = 1'b0;
      end
    end
    if (freq_q[lpf_pkg::FREQ_TOP_BIT]) begin
      fmode_d = lpf_pkg::FREQ_2M00;
    end else if (freq_q[lpf_pkg::FREQ_MID_BIT]) begin
      fmode_d = lpf_pkg::FREQ_1M67;
    end else begin
      fmode_d = lpf_pkg::FREQ_1M00;
    end
  end

  // decoded setting registers
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      step_q  <= 4'h6;
      fmode_q <= lpf_pkg::FREQ_2M00;
    end else begin
      step_q  <= step_d;
      fmode_q <= fmode_d;
    end
  end

  // flash timer hookup
  lpf_flash_if fl_if ();
  assign fl_if.drv_en  = flash_q[lpf_pkg::FL_EN_BIT];
  assign fl_if.safe_en = flash_q[lpf_pkg::FL_SAFE_BIT];
  assign fl_if.dim_en  = flash_q[lpf_pkg::FL_DIM_BIT];
  assign fl_if.dur     = flash_q[lpf_pkg::FL_DUR_LSB +: 2];
  assign fl_if.trig    = trig_lvl;
  assign fl_if.dim     = dim_lvl;
  lpf_flash_timer #(.DUR0_CYC(DUR0_CYC), .DUR1_CYC(DUR1_CYC), .DUR2_CYC(DUR2_CYC)) u_flash (
    .mclk_in(mclk_in), .resetn_in(resetn_in), .fl(fl_if.timer));

  // outputs, all from flops
  assign sda_out                  = sda_q;
  assign sda_oe_n_out             = oe_n_q;
  assign flash_drive_out          = fl_if.drive;
  assign flash_current_select_out = flash_q[lpf_pkg::FL_CUR_LSB +: 2];
  assign boost_step_out           = step_q;
  assign freq_mode_out            = fmode_q;
  assign blink_enable_out         = pat_q[lpf_pkg::PG_BLINK_BIT];
  assign pattern_run_out          = pat_q[lpf_pkg::PG_START_BIT];
  assign pattern_restart_out      = restart_q;
  assign pattern_loop_out         = pat_q[lpf_pkg::PG_LOOP_BIT];
  assign intensity_mode_out       = pat_q[lpf_pkg::PG_MODE_BIT];
  assign group1_red_ceiling_out   = ceil1_q[lpf_pkg::CEIL_RED_LSB +: 2];
  assign group1_green_ceiling_out = ceil1_q[lpf_pkg::CEIL_GREEN_LSB +: 2];
  assign group1_blue_ceiling_out  = ceil1_q[lpf_pkg::CEIL_BLUE_LSB +: 2];
  assign group2_red_ceiling_out   = ceil2_q[lpf_pkg::CEIL_RED_LSB +: 2];
  assign group2_green_ceiling_out = ceil2_q[lpf_pkg::CEIL_GREEN_LSB +: 2];
  assign group2_blue_ceiling_out  = ceil2_q[lpf_pkg::CEIL_BLUE_LSB +: 2];
endmodule : lpf_regs

// *** dv/lpf_regs_monitor.sv ***
// port-level assertions for the lighting register bank
`timescale 1ns/1ps
module lpf_regs_checker (
  // clock and reset
  input wire logic       mclk_in,
  input wire logic       resetn_in,
  // flash pins
  input wire logic       flash_trigger_in,
  input wire logic       flash_drive_out,
  // register outputs
  input wire logic [3:0] boost_step_out,
  input wire logic [1:0] freq_mode_out,
  input wire logic       pattern_run_out,
  input wire logic       pattern_restart_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!resetn_in);

  // first edge after reset is let go
  sequence s_rst_done;
    $rose(resetn_in);
  endsequence
  // one-cycle restart while the run bit is up
  sequence s_pulse;
    (pattern_restart_out && pattern_run_out) ##1 !pattern_restart_out;
  endsequence

  property p_step_range;
    boost_step_out <= 4'h8;
  endproperty
  a_step_range: assert property (p_step_range) else $error("boost step above eight");
  property p_step_reset;
    s_rst_done |-> boost_step_out == 4'h6;
  endproperty
  a_step_reset: assert property (p_step_reset) else $error("boost step not six after reset");
  property p_freq_code;
    freq_mode_out != 2'h3;
  endproperty
  a_freq_code: assert property (p_freq_code) else $error("frequency mode code unused value");
  property p_freq_reset;
    s_rst_done |-> freq_mode_out == 2'h2;
  endproperty
  a_freq_reset: assert property (p_freq_reset) else $error("frequency mode not highest after reset");
  property p_run_start;
    $rose(pattern_run_out) |-> s_pulse;
  endproperty
  a_run_start: assert property (p_run_start) else $error("run rose without single restart pulse");
  property p_restart_cause;
    pattern_restart_out |-> $rose(pattern_run_out);
  endproperty
  a_restart_cause: assert property (p_restart_cause) else $error("restart without run rising");
  property p_drive_cause;
    $rose(flash_drive_out) |-> $past(flash_trigger_in, 3);
  endproperty
  a_drive_cause: assert property (p_drive_cause) else $error("flash drive rose without trigger");
  property p_idle_reset;
    s_rst_done |-> !flash_drive_out && !pattern_run_out && !pattern_restart_out;
  endproperty
  a_idle_reset: assert property (p_idle_reset) else $error("flash or pattern active after reset");
endmodule : lpf_regs_checker

bind lpf_regs lpf_regs_checker u_lpf_regs_checker (
  .mclk_in             (mclk_in),
  .resetn_in           (resetn_in),
  .flash_trigger_in    (flash_trigger_in),
  .flash_drive_out     (flash_drive_out),
  .boost_step_out      (boost_step_out),
  .freq_mode_out       (freq_mode_out),
  .pattern_run_out     (pattern_run_out),
  .pattern_restart_out (pattern_restart_out)
);

// *** dv/lpf_host.sv ***
// serial bus host model: drives clock and data, samples the wire
`timescale 1ns/1ps
module lpf_host (
  // clock
  input  wire logic mclk_in,
  // data wire level, pulled up
  input  wire logic sda_w_in,
  // host drive levels, 1 means released
  output logic      scl_out,
  output logic      sda_out
);
  // low phase is this plus three; high phase is twice this, both above the pin filter span
  localparam int HALF = 9;
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  // changes land on falling edges only
  task automatic hw(input int n);
    repeat (n) @(negedge mclk_in);
  endtask : hw
  // start, also used as repeated start
  task automatic start;
    sda_out = 1'b1;
    hw(HALF);
    scl_out = 1'b1;
    hw(HALF);
    sda_out = 1'b0;
    hw(HALF);
    scl_out = 1'b0;
    hw(3);
  endtask : start
  task automatic stop;
    sda_out = 1'b0;
    hw(HALF);
    scl_out = 1'b1;
    hw(HALF);
    sda_out = 1'b1;
    hw(HALF);
  endtask : stop
  // hold after clock fall so filtered data never moves before filtered clock
  task automatic bit_io(input logic b, output logic s);
    sda_out = b;
    hw(HALF);
    scl_out = 1'b1;
    hw(HALF);
    s = sda_w_in;
    hw(HALF);
    scl_out = 1'b0;
    hw(3);
  endtask : bit_io
  task automatic tx(input logic [7:0] d, output logic ack_n);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, ack_n);
  endtask : tx
  // last byte is answered by releasing, which ends the read
  task automatic rx(input logic last, output logic [7:0] q);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      q[i] = s;
    end
    bit_io(last, s);
  endtask : rx
endmodule : lpf_host

// *** dv/lpf_regs_test.sv ***
// self-checking bench for the lighting register bank
`timescale 1ns/1ps
module lpf_regs_test;
  localparam logic [6:0] DEV = 7'h2A; // arbitrary bus address
  localparam int         D0  = 20;
  localparam int         D1  = 40;
  localparam int         D2  = 60;
  logic       mclk_in          = 1'b0;
  logic       resetn_in        = 1'b0;
  logic       flash_trigger_in = 1'b0;
  logic       flash_dim_in     = 1'b0;
  logic       scl_in;
  logic       sda_in;
  logic       host_sda;
  logic       sda_out;
  logic       sda_oe_n_out;
  logic       flash_drive_out;
  logic [1:0] flash_current_select_out;
  logic [3:0] boost_step_out;
  logic [1:0] freq_mode_out;
  logic       blink_enable_out;
  logic       pattern_run_out;
  logic       pattern_restart_out;
  logic       pattern_loop_out;
  logic       intensity_mode_out;
  logic [1:0] group1_red_ceiling_out;
  logic [1:0] group1_green_ceiling_out;
  logic [1:0] group1_blue_ceiling_out;
  logic [1:0] group2_red_ceiling_out;
  logic [1:0] group2_green_ceiling_out;
  logic [1:0] group2_blue_ceiling_out;
  int         errors    = 0;
  int         tests_run = 0;
  int         restarts  = 0;
  int         dur[3]    = '{D0, D1, D2};

  always #2.5 mclk_in = ~mclk_in;
  // wired-and data line with pull-up
  assign sda_in = host_sda & (sda_oe_n_out | sda_out);
  // pulses counted mid-cycle, where the registered output has settled
  always @(negedge mclk_in) begin
    if (pattern_restart_out === 1'b1) restarts++;
  end

  lpf_regs #(.DUR0_CYC(D0), .DUR1_CYC(D1), .DUR2_CYC(D2)) u_lpf_regs (
    .mclk_in, .resetn_in, .scl_in, .sda_in, .sda_out, .sda_oe_n_out,
    .flash_trigger_in, .flash_dim_in, .flash_drive_out, .flash_current_select_out,
    .boost_step_out, .freq_mode_out, .blink_enable_out, .pattern_run_out,
    .pattern_restart_out, .pattern_loop_out, .intensity_mode_out,
    .group1_red_ceiling_out, .group1_green_ceiling_out, .group1_blue_ceiling_out,
    .group2_red_ceiling_out, .group2_green_ceiling_out, .group2_blue_ceiling_out
  );
  lpf_host u_lpf_host (.mclk_in(mclk_in), .sda_w_in(sda_in), .scl_out(scl_in), .sda_out(host_sda));

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [2:0] k;
    u_lpf_host.start();
    u_lpf_host.tx({DEV, 1'b0}, k[2]);
    u_lpf_host.tx(a, k[1]);
    u_lpf_host.tx(d, k[0]);
    u_lpf_host.stop();
    chk("write ack", 8'h00, {5'h00, k});
  endtask : wr
  // pointer set by a write frame, then repeated start for the read
  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
    logic [2:0] k;
    logic [7:0] q;
    u_lpf_host.start();
    u_lpf_host.tx({DEV, 1'b0}, k[2]);
    u_lpf_host.tx(a, k[1]);
    u_lpf_host.start();
    u_lpf_host.tx({DEV, 1'b1}, k[0]);
    u_lpf_host.rx(1'b1, q);
    u_lpf_host.stop();
    chk("read ack", 8'h00, {5'h00, k});
    chk(nm, exp, q);
  endtask : rchk
  task automatic do_reset;
    resetn_in = 1'b0;
    repeat (8) @(negedge mclk_in);
    resetn_in = 1'b1;
    repeat (6) @(negedge mclk_in);
  endtask : do_reset
  // trigger held for len cycles, drive cycles counted
  task automatic flash(input int len, output int n);
    n = 0;
    flash_trigger_in = 1'b1;
    for (int i = 0; i < 200; i++) begin
      if (i == len) flash_trigger_in = 1'b0;
      @(negedge mclk_in);
      if (flash_drive_out === 1'b1) n++;
    end
  endtask : flash
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    logic [7:0] v;
    int         n;
    int         r0;
    do_reset();
    v = 8'h00;
    for (int k = 0; k <= 8; k++) begin
      wr(8'h0D, v);
      chk("boost step", 8'(k), {4'h0, boost_step_out});
      rchk("boost reg", 8'h0D, v);
      v = {v[6:0], 1'b1};
    end
    $display("test boost done");
    for (int k = 0; k < 8; k++) begin
      wr(8'h0E, 8'hF8 | 8'(k));
      chk("freq mode", (k > 3) ? 8'h02 : (k > 1) ? 8'h01 : 8'h00, {6'h00, freq_mode_out});
      rchk("freq reg", 8'h0E, 8'(k));
    end
    $display("test frequency done");
    r0 = restarts;
    wr(8'h11, 8'hFF);
    chk("pattern bits", 8'h0F, {blink_enable_out, pattern_run_out, pattern_loop_out, intensity_mode_out});
    chk("restarts", 8'h01, 8'(restarts - r0));
    rchk("pattern reg", 8'h11, 8'h0F);
    wr(8'h11, 8'h05);
    chk("pattern bits", 8'h05, {blink_enable_out, pattern_run_out, pattern_loop_out, intensity_mode_out});
    chk("restarts", 8'h01, 8'(restarts - r0));
    wr(8'h11, 8'h00);
    chk("run", 8'h00, {7'h00, pattern_run_out});
    wr(8'h11, 8'h04);
    chk("restarts", 8'h02, 8'(restarts - r0));
    $display("test pattern done");
    wr(8'h12, 8'hE4);
    chk("group1", 8'h24, {2'h0, group1_red_ceiling_out, group1_green_ceiling_out, group1_blue_ceiling_out});
    rchk("group1 reg", 8'h12, 8'h24);
    wr(8'h13, 8'hDB);
    chk("group2", 8'h1B, {2'h0, group2_red_ceiling_out, group2_green_ceiling_out, group2_blue_ceiling_out});
    rchk("group2 reg", 8'h13, 8'h1B);
    wr(8'h0F, 8'hA5);
    rchk("unmapped", 8'h0F, 8'h00);
    $display("test ceilings done");
    for (int c = 0; c < 4; c++) begin
      wr(8'h10, 8'h80 | 8'(c << 1));
      chk("flash current", 8'(c), {6'h00, flash_current_select_out});
      rchk("flash reg", 8'h10, 8'(c << 1));
    end
    flash(10, n);
    chk("drive while disabled", 8'h00, 8'(n));
    for (int d = 0; d < 3; d++) begin
      wr(8'h10, 8'(d << 3) | 8'h07);
      flash(10, n);
      chk("timed flash", 8'(dur[d]), 8'(n));
    end
    wr(8'h10, 8'h19);
    flash(100, n);
    chk("pin held flash", 8'h01, {7'h00, n >= 99 && n <= 101});
    wr(8'h10, 8'h59);
    flash(100, n);
    chk("timeout cap", 8'(D2), 8'(n));
    wr(8'h10, 8'h21);
    flash(10, n);
    chk("dim low", 8'h00, 8'(n));
    flash_dim_in = 1'b1;
    flash(10, n);
    chk("dim high", 8'(D0), 8'(n));
    $display("test flash done");
    do_reset();
    chk("step after reset", 8'h06, {4'h0, boost_step_out});
    chk("freq after reset", 8'h02, {6'h00, freq_mode_out});
    rchk("boost rst", 8'h0D, 8'h3F);
    rchk("freq rst", 8'h0E, 8'h07);
    rchk("flash rst", 8'h10, 8'h00);
    rchk("pattern rst", 8'h11, 8'h00);
    rchk("group1 rst", 8'h12, 8'h00);
    rchk("group2 rst", 8'h13, 8'h00);
    $display("test reset done");
    give_verdict();
  end

  // expected run is near 70000 cycles; limit kept near 90000 so a hang ends early
  initial begin
    #450us;
    errors++;
    give_verdict();
  end
endmodule : lpf_regs_test
